// ==== logic/hia_aggregator.sv ====
// Interrupt aggregator for a four receive, two transmit port hub.
//
// Contract
// - Receive port enables at control bits 3..0.
// - Global bit 7 set by enabled pending source.
// - Master enable does not mask global bit.
// - Read-only status register with fixed bit layout.
// - Transmit flag clears on its port status read.
// - Receive flag clears after all causing reads.
// - Master enable bit 7 gates host interrupt.
// - Transmit and receive 3 enables at bits 5..3.
`timescale 1ns/100ps
`default_nettype none
module hia_aggregator #(
  parameter int NUM_RX = hia_pkg::NUM_RX,
  parameter int NUM_TX = hia_pkg::NUM_TX
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output var  logic [7:0]        reg_rdata,
  input  wire logic [NUM_RX-1:0] rx_event,
  input  wire logic [NUM_RX-1:0] rx_status_a_read,
  input  wire logic [NUM_RX-1:0] rx_status_b_read,
  input  wire logic [NUM_RX-1:0] serial_rx_status_read,
  input  wire logic [NUM_TX-1:0] tx_event,
  input  wire logic [NUM_TX-1:0] tx_status_read,
  output var  logic              irq_out
);

  // Source count of the summary; receive ports first, transmit ports above them.
  localparam int NUM_SRC = NUM_RX + NUM_TX;

  // Control register and the pending flags of every source.
  logic [7:0]         interrupt_enable_control;
  logic [NUM_RX-1:0]  rx_irq_flag;
  logic [NUM_TX-1:0]  tx_irq_flag;

  // Per receive port: which causing registers were read since the last cause.
  logic [NUM_RX-1:0]  rx_read_a_seen;
  logic [NUM_RX-1:0]  rx_read_b_seen;
  logic [NUM_RX-1:0]  rx_read_c_seen;

  // Decoded register strobes.
  logic               control_write;
  logic               control_read;
  logic               status_read;
  logic               other_read;

  // Per source clear conditions.
  logic [NUM_RX-1:0]  rx_clear_now;
  logic [NUM_RX-1:0]  rx_history_reset;
  logic [NUM_TX-1:0]  tx_clear_now;

  // Combinational images of the registers and of the host request.
  logic [NUM_SRC-1:0] source_irq_flags;
  logic [NUM_SRC-1:0] source_irq_enables;
  logic               next_global;
  logic [7:0]         next_summary;
  logic [7:0]         next_rdata;
  logic               next_irq;

  // Address match, shared by the write and read paths so both see one map.
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return addr == target;
  endfunction

  // A receive cause is serviced once each causing register was read, in any order.
  // A read in the current cycle counts, so the last read clears on its own edge.
  function automatic logic reads_complete(
    input logic seen_a,
    input logic seen_b,
    input logic seen_c,
    input logic now_a,
    input logic now_b,
    input logic now_c
  );
    return (seen_a || now_a) && (seen_b || now_b) && (seen_c || now_c);
  endfunction

  // Register decode; writes to the status address and to holes fall through unused.
  assign control_write = reg_write && addr_hit(reg_addr, hia_pkg::ADDR_ENABLE_CONTROL);
  assign control_read  = reg_read && addr_hit(reg_addr, hia_pkg::ADDR_ENABLE_CONTROL);
  assign status_read   = reg_read && addr_hit(reg_addr, hia_pkg::ADDR_SUMMARY_STATUS);
  assign other_read    = reg_read && !control_read && !status_read;

  // Control register write; reserved bit 6 is masked so it always reads back as zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interrupt_enable_control <= hia_pkg::ENABLE_CONTROL_RESET;
    end else if (control_write) begin
      interrupt_enable_control <= reg_wdata & hia_pkg::ENABLE_CONTROL_MASK;
    end
  end

  // Receive ports: one flag and three read histories each.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RX; gi++) begin : g_rx
      // Clear once the last outstanding causing register has been read.
      assign rx_clear_now[gi] = rx_irq_flag[gi] && reads_complete(
        rx_read_a_seen[gi], rx_read_b_seen[gi], rx_read_c_seen[gi],
        rx_status_a_read[gi], rx_status_b_read[gi], serial_rx_status_read[gi]);

      // History restarts on a new cause, so reads of an old cause never clear a new one.
      assign rx_history_reset[gi] = rx_event[gi] || rx_clear_now[gi];

      // Flag; a cause in the clearing cycle wins, so no event is lost.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          rx_irq_flag[gi] <= 1'b0;
        end else if (rx_event[gi]) begin
          rx_irq_flag[gi] <= 1'b1;
        end else if (rx_clear_now[gi]) begin
          rx_irq_flag[gi] <= 1'b0;
        end
      end

      // First causing register; reads while no flag stands are not remembered.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          rx_read_a_seen[gi] <= 1'b0;
        end else if (rx_history_reset[gi]) begin
          rx_read_a_seen[gi] <= 1'b0;
        end else if (rx_irq_flag[gi] && rx_status_a_read[gi]) begin
          rx_read_a_seen[gi] <= 1'b1;
        end
      end

      // Second causing register, same rules as the first.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          rx_read_b_seen[gi] <= 1'b0;
        end else if (rx_history_reset[gi]) begin
          rx_read_b_seen[gi] <= 1'b0;
        end else if (rx_irq_flag[gi] && rx_status_b_read[gi]) begin
          rx_read_b_seen[gi] <= 1'b1;
        end
      end

      // Serial receive status register, same rules again.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          rx_read_c_seen[gi] <= 1'b0;
        end else if (rx_history_reset[gi]) begin
          rx_read_c_seen[gi] <= 1'b0;
        end else if (rx_irq_flag[gi] && serial_rx_status_read[gi]) begin
          rx_read_c_seen[gi] <= 1'b1;
        end
      end
    end

    for (gi = 0; gi < NUM_TX; gi++) begin : g_tx
      // Only the port's own status read clears the flag; summary reads never do.
      assign tx_clear_now[gi] = tx_status_read[gi];

      // Flag; a cause in the clearing cycle wins here as well.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          tx_irq_flag[gi] <= 1'b0;
        end else if (tx_event[gi]) begin
          tx_irq_flag[gi] <= 1'b1;
        end else if (tx_clear_now[gi]) begin
          tx_irq_flag[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Sources in summary order: receive ports in the low bits, transmit ports above.
  assign source_irq_flags   = {tx_irq_flag, rx_irq_flag};
  assign source_irq_enables =
    interrupt_enable_control[hia_pkg::BIT_TX1:hia_pkg::BIT_RX0];

  // Master enable deliberately left out: software sees a pending cause even while masked.
  always_comb begin
    next_global  = |(source_irq_flags & source_irq_enables);
    next_summary = hia_pkg::SUMMARY_STATUS_RESET;
    next_summary[hia_pkg::BIT_RX3:hia_pkg::BIT_RX0] = rx_irq_flag;
    next_summary[hia_pkg::BIT_TX1:hia_pkg::BIT_TX0] = tx_irq_flag;
    next_summary[hia_pkg::BIT_GLOBAL]               = next_global;
  end

  // Read data selection; holes read as zero and no read changes any state.
  always_comb begin
    next_rdata = reg_rdata;
    if (status_read) begin
      next_rdata = next_summary;
    end else if (control_read) begin
      next_rdata = interrupt_enable_control;
    end else if (other_read) begin
      next_rdata = '0;
    end
  end

  // Read data register; it holds between reads so the host may fetch it late.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Host request; the master enable gates the aggregated bit onto the pin.
  assign next_irq = interrupt_enable_control[hia_pkg::BIT_GLOBAL] && next_global;

  // Registered, so the pin carries no combinational path from the register bus.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end

endmodule
`default_nettype wire

// ==== shared/hia_pkg.sv ====
// Package with register offsets, field positions and reset values of the interrupt aggregator.
package hia_pkg;
  localparam logic [7:0] ADDR_ENABLE_CONTROL = 8'h23;
  localparam logic [7:0] ADDR_SUMMARY_STATUS = 8'h24;
  localparam logic [7:0] ENABLE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SUMMARY_STATUS_RESET = 8'h00;
  // Field positions shared by both registers.
  localparam int BIT_RX0    = 0;
  localparam int BIT_RX3    = 3;
  localparam int BIT_TX0    = 4;
  localparam int BIT_TX1    = 5;
  localparam int BIT_RSVD   = 6;
  localparam int BIT_GLOBAL = 7;
  localparam int NUM_RX     = 4;
  localparam int NUM_TX     = 2;
  localparam int NUM_SRC    = 6;
  // Writable bits of the control register; bit 6 is reserved.
  localparam logic [7:0] ENABLE_CONTROL_MASK = 8'hBF;
endpackage

// ==== tb/hia_chk_sva.sv ====
// Port checker of the interrupt aggregator.
`timescale 1ns/100ps
`default_nettype none
module hia_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic       irq_out,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] tx_event,
  input wire logic [1:0] tx_status_read,
  input wire logic [3:0] rx_event,
  input wire logic [3:0] rx_status_a_read,
  input wire logic [3:0] rx_status_b_read,
  input wire logic [3:0] serial_rx_status_read
);
  // Helpers keep the property lines short; unmapped covers every hole in the map.
  wire logic unmapped = !(reg_addr inside {8'h23, 8'h24});
  wire logic cause    = reg_write || (|tx_event) || (|rx_event);
  wire logic rx0_done = rx_status_a_read[0] && rx_status_b_read[0] && serial_rx_status_read[0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence ctl_wr; reg_write && reg_addr == 8'h23; endsequence
  sequence ctl_rd; reg_read && reg_addr == 8'h23; endsequence
  sequence sts_rd; reg_read && reg_addr == 8'h24; endsequence
  sequence tx0_cleared; tx_status_read[0] && !tx_event[0] ##1 !tx_event[0]; endsequence
  sequence rx0_cleared; rx0_done && !rx_event[0] ##1 !rx_event[0]; endsequence
  rst_zero_a: assert property (disable iff (1'b0) rst |=> !irq_out && !reg_rdata)
    else $error("outputs not cleared by reset");
  rsvd_zero_a: assert property (!reg_rdata[6]) else $error("reserved bit set");
  unmapped_a: assert property (reg_read && unmapped |=> !reg_rdata) else $error("hole");
  rd_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("rdata moved");
  master_off_a: assert property (ctl_wr ##0 !reg_wdata[7] |=> ##1 !irq_out)
    else $error("irq with master enable off");
  ctl_back_a: assert property (ctl_wr ##1 !reg_write ##1 ctl_rd
    |=> reg_rdata == ($past(reg_wdata, 3) & 8'hBF)) else $error("control readback");
  irq_cause_a: assert property ($rose(irq_out) |-> $past(cause, 2))
    else $error("irq no cause");
  irq_global_a: assert property (sts_rd |=> !irq_out || reg_rdata[7])
    else $error("irq without global bit");
  tx_clear_a: assert property (tx0_cleared ##1 sts_rd |=> !reg_rdata[4])
    else $error("transmit flag kept");
  rx_clear_a: assert property (rx0_cleared ##1 sts_rd |=> !reg_rdata[0])
    else $error("receive flag kept");
endmodule
bind hia_aggregator hia_chk hia_chk_i (.clk_sys, .rst, .reg_write, .reg_read, .irq_out,
  .reg_addr, .reg_wdata, .reg_rdata, .tx_event, .tx_status_read, .rx_event,
  .rx_status_a_read, .rx_status_b_read, .serial_rx_status_read);
`default_nettype wire

// ==== tb/hia_host.sv ====
// Host model that counts the cycles in which it sees the interrupt request.
`timescale 1ns/100ps
`default_nettype none
module hia_host (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        irq_out,
  output var  logic [15:0] seen
);
  // Servicing reads come from the bench, so the host only samples the level.
  always_ff @(posedge clk_sys) begin
    seen <= rst ? 16'h0000 : seen + 16'(irq_out);
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Random and corner tests of the interrupt aggregator.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, irq_out;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, en = 8'h00, ex, d;
  logic [3:0] rx_event = 4'h0, rx_status_a_read = 4'h0, rx_status_b_read = 4'h0;
  logic [3:0] serial_rx_status_read = 4'h0, ha = 4'h0, hb = 4'h0, hs = 4'h0;
  logic [1:0] tx_event = 2'h0, tx_status_read = 2'h0;
  logic [5:0] f = 6'h00;
  logic [15:0] seen;
  logic [31:0] s = 32'h0000680C;
  int mismatches = 0, compares = 0, cyc = 0;
  hia_aggregator hia_aggregator_i (.clk_sys, .rst, .reg_write, .reg_read, .reg_addr, .reg_wdata,
    .reg_rdata, .rx_event, .rx_status_a_read, .rx_status_b_read, .serial_rx_status_read,
    .tx_event, .tx_status_read, .irq_out);
  hia_host hia_host_i (.clk_sys, .rst, .irq_out, .seen);
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // Expected read data: the global bit uses enabled sources only, never the master enable.
  function automatic logic [7:0] exp_rdata(logic [7:0] ad, logic [7:0] ctl, logic [5:0] fl);
    logic g;
    g = |(fl & ctl[5:0]);
    return ad == 8'h24 ? {g, 1'b0, fl} : ad == 8'h23 ? ctl : 8'h00;
  endfunction
  // Expected host request: master enable and at least one enabled pending source.
  function automatic logic exp_irq(logic [7:0] ctl, logic [5:0] fl);
    return ctl[7] & (|(fl & ctl[5:0]));
  endfunction
  // One access with events and clearing reads; the model moves only after the expectation.
  task automatic op(logic w, logic r, logic [7:0] ad, logic [7:0] dat, logic [5:0] e,
                    logic [13:0] c);
    logic ei;
    ei = exp_irq(en, f);
    ex = exp_rdata(ad, en, f);
    @(posedge clk_sys);
    {reg_write, reg_read, reg_addr, reg_wdata, tx_event, rx_event} <= {w, r, ad, dat, e};
    {tx_status_read, rx_status_a_read, rx_status_b_read, serial_rx_status_read} <= c;
    @(posedge clk_sys);
    {reg_write, reg_read, tx_event, rx_event} <= '0;
    {tx_status_read, rx_status_a_read, rx_status_b_read, serial_rx_status_read} <= '0;
    #1 d = reg_rdata;
    if (r) `CHK(d, ex)
    `CHK(irq_out, ei)
    if (w && ad == 8'h23) en = dat & 8'hBF;
    f[5:4] &= ~c[13:12];
    {ha, hb, hs} |= c[11:0];
    f[3:0] &= ~(ha & hb & hs);
    f |= e;
    {ha, hb, hs} &= ~{3{e[3:0]}};
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always #25 clk_sys = ~clk_sys;
  // Each op takes two cycles, some 1,210 in all, so the ceiling leaves ample margin.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin mismatches++; final_report(); end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    op(1'b0, 1'b1, 8'h23, '0, '0, '0);
    op(1'b0, 1'b1, 8'h24, '0, '0, '0);
    // Events on every port meet all clearing reads in one cycle, and bit 6 is written.
    op(1'b1, 1'b0, 8'h23, 8'hFF, 6'h3F, 14'h3FFF);
    op(1'b0, 1'b1, 8'h24, '0, '0, '0);
    repeat (300) begin
      s = xs(s);
      op(s[16], 1'b0, {7'h11, s[15]} + 8'h01, s[7:0], s[13:8] & ~f, s[31:18]);
      op(1'b0, 1'b1, 8'h23 + 8'(s[18:17]), '0, '0, '0);
    end
    `CHK(|seen, 1'b1)
    final_report();
  end
endmodule
`default_nettype wire
